// ---- design/cluster_reset_clock_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "crcs_regs.svh"

module cluster_reset_clock_sequencer #(
	parameter int CPUS      = 2,  // processors in the cluster, 1 or 2
	parameter int LOCKSTEP  = 1,  // lock-step build with clock-stop handshake
	parameter int RED_DELAY = 2   // main-to-redundant core delay in clk cycles, at least 1
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// classic wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output var  logic [31:0]       wb_dat_o,
	output var  logic              wb_ack_o,
	// clocks toward the cluster
	output var  logic              main_clock_run_o,
	output var  logic              peripheral_clock_o,
	output var  logic              peripheral_clock_enable_o,
	output wire logic              redundant_peripheral_clock_o,
	output wire logic              redundant_peripheral_clock_enable_o,
	// clock stops
	output var  logic [CPUS-1:0]   core_clock_stop_o,
	output var  logic              coherency_unit_clock_stop_o,
	output var  logic              peripheral_clock_stop_o,
	output var  logic              redundant_peripheral_clock_stop_o,
	// resets, active low
	output var  logic [CPUS-1:0]   core_reset_n_o,
	output var  logic [CPUS-1:0]   debug_logic_reset_n_o,
	output var  logic [CPUS-1:0]   watchdog_flag_reset_n_o,
	output var  logic              coherency_unit_reset_n_o,
	output var  logic              peripheral_reset_n_o,
	output var  logic              cross_trigger_reset_n_o,
	output var  logic              trace0_reset_n_o,
	output var  logic              trace1_reset_n_o
);

	logic [7:0]                      ratio_r;
	logic [7:0]                      hold_r;
	logic [7:0]                      settle_r;
	logic [7:0]                      ratio_act_r;
	logic [7:0]                      pcnt_r;
	logic [7:0]                      pcnt_nxt;
	logic [7:0]                      half;
	logic [7:0]                      cnt_r;
	logic [7:0]                      cnt_nxt;
	logic [7:0]                      hold_eff;
	logic [7:0]                      settle_eff;
	logic                            done_r;
	logic                            refused_r;
	logic                            req;
	logic                            wr_fire;
	logic                            start_wr;
	logic                            cmd_ok;
	logic                            go;
	logic                            finish;
	logic                            busy;
	logic                            full_seq;
	logic                            cluster_kind;
	logic                            assert_nxt;
	logic                            gate_nxt;
	logic                            stop_nxt;
	crcs_pkg::command_type           cmd_r;
	crcs_pkg::command_type           cmd_wr;
	crcs_pkg::seq_state_type         state_r;
	crcs_pkg::seq_state_type         state_nxt;
	crcs_pkg::reset_pattern_type     pat;
	logic [RED_DELAY:0][2:0]         taps;
	logic [1:0]                      stop_sel;

	// one-hot select of the addressed core
	function automatic logic [1:0] core_sel(input logic cpu);
		core_sel = cpu ? 2'b10 : 2'b01;
	endfunction : core_sel

	// raise a programmed value to its floor
	function automatic logic [7:0] at_least(input logic [7:0] val, input logic [7:0] floor);
		at_least = (val < floor) ? floor : val;
	endfunction : at_least

	// cluster power-up and software kinds gate the main clock, core power-up and software kinds the core clock
	function automatic logic is_cluster(input crcs_pkg::reset_kind_type kind);
		is_cluster = (kind == crcs_pkg::KIND_CLUSTER_POWERUP) || (kind == crcs_pkg::KIND_CLUSTER_SOFTWARE);
	endfunction : is_cluster

	// reset levels per kind of sequence
	function automatic crcs_pkg::reset_pattern_type pattern(input crcs_pkg::command_type cmd);
		logic [1:0] nsel;
		nsel = ~core_sel(cmd.cpu);
		pattern = '1;
		case (cmd.kind)
			crcs_pkg::KIND_CLUSTER_POWERUP: begin
				pattern = '0;
			end
			crcs_pkg::KIND_CLUSTER_SOFTWARE: begin
				pattern.core_n    = 2'b00;
				pattern.wd_n      = 2'b00;
				pattern.cluster_n = 1'b0;
			end
			crcs_pkg::KIND_CORE_POWERUP: begin
				pattern.core_n  = nsel;
				pattern.debug_n = nsel;
				pattern.wd_n    = cmd.wd_opt ? nsel : 2'b11;
			end
			crcs_pkg::KIND_CORE_SOFTWARE: begin
				pattern.core_n = nsel;
				pattern.wd_n   = cmd.wd_opt ? nsel : 2'b11;
			end
			crcs_pkg::KIND_CLUSTER_DEBUG: begin
				pattern.debug_n = 2'b00;
			end
			crcs_pkg::KIND_CORE_DEBUG: begin
				pattern.debug_n = nsel;
			end
			crcs_pkg::KIND_WATCHDOG_FLAG: begin
				pattern.wd_n = nsel;
			end
			default: begin
				pattern = '1;
			end
		endcase
	endfunction : pattern

	// bus decode; writes land on the edge where the master sees ack
	assign req      = wb_cyc_i & wb_stb_i;
	assign wr_fire  = req & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign start_wr = wr_fire && (wb_adr_i == `CRCS_ADR_CTRL) && wb_dat_i[`CRCS_CTRL_START];
	assign cmd_wr   = crcs_pkg::command_type'(wb_dat_i[`CRCS_CTRL_TOP:`CRCS_CTRL_KIND_LO]);
	assign cmd_ok   = (int'(cmd_wr.kind) <= int'(crcs_pkg::KIND_WATCHDOG_FLAG)) && ((CPUS == 2) || !cmd_wr.cpu);
	assign go       = start_wr && (state_r == crcs_pkg::S_IDLE) && cmd_ok;
	assign busy     = (state_r != crcs_pkg::S_IDLE);

	// ack one cycle after the request is seen, dropped in the next
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
		end
	end

	// read data registered together with ack; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (req & ~wb_ack_o) begin
			case (wb_adr_i)
				`CRCS_ADR_CTRL:   wb_dat_o <= 32'({cmd_r, 1'b0});
				`CRCS_ADR_STATUS: wb_dat_o <= 32'({refused_r, done_r, busy});
				`CRCS_ADR_RATIO:  wb_dat_o <= 32'(ratio_r);
				`CRCS_ADR_HOLD:   wb_dat_o <= 32'(hold_r);
				`CRCS_ADR_SETTLE: wb_dat_o <= 32'(settle_r);
				default:          wb_dat_o <= '0;
			endcase
		end
	end

	// timing configuration; unmapped writes are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ratio_r  <= `CRCS_RATIO_RST;
			hold_r   <= `CRCS_HOLD_RST;
			settle_r <= `CRCS_SETTLE_RST;
		end else if (wr_fire) begin
			case (wb_adr_i)
				`CRCS_ADR_RATIO:  ratio_r  <= wb_dat_i[7:0];
				`CRCS_ADR_HOLD:   hold_r   <= wb_dat_i[7:0];
				`CRCS_ADR_SETTLE: settle_r <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	// sticky flags, write one to clear; a new event beats the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_r    <= 1'b0;
			refused_r <= 1'b0;
		end else begin
			done_r    <= finish | (done_r & ~(wr_fire && (wb_adr_i == `CRCS_ADR_STATUS) && wb_dat_i[`CRCS_ST_DONE]));
			refused_r <= (start_wr & ~go) |
				(refused_r & ~(wr_fire && (wb_adr_i == `CRCS_ADR_STATUS) && wb_dat_i[`CRCS_ST_REFUSED]));
		end
	end

	// latched command; power-on runs a cold cluster reset by itself
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_r <= '{wd_opt: 1'b0, cpu: 1'b0, kind: crcs_pkg::KIND_CLUSTER_POWERUP};
		end else if (go) begin
			cmd_r <= cmd_wr;
		end
	end

	// floors guard against software shortening below what the cluster needs
	assign hold_eff     = at_least(hold_r, `CRCS_HOLD_MIN);
	assign settle_eff   = at_least(settle_r, `CRCS_SETTLE_MIN);
	assign full_seq     = int'(cmd_r.kind) <= int'(crcs_pkg::KIND_CORE_SOFTWARE);
	assign cluster_kind = is_cluster(cmd_r.kind);
	assign finish       = (cnt_r == 8'h00) &&
		((state_r == crcs_pkg::S_RELEASED) || ((state_r == crcs_pkg::S_ASSERT) && !full_seq));

	// sequencer: assert, hold, stop clock, settle, release, settle, restart
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			crcs_pkg::S_IDLE: begin
				if (go) begin
					state_nxt = crcs_pkg::S_ASSERT;
					cnt_nxt   = hold_eff - 8'h01;
				end
			end
			crcs_pkg::S_ASSERT: begin
				if (cnt_r != 8'h00) begin
					cnt_nxt = cnt_r - 8'h01;
				end else if (!full_seq) begin
					state_nxt = crcs_pkg::S_IDLE;
				end else if ((LOCKSTEP != 0) && cluster_kind) begin
					state_nxt = crcs_pkg::S_STOPS;
				end else begin
					state_nxt = crcs_pkg::S_GATED;
					cnt_nxt   = settle_eff - 8'h01;
				end
			end
			crcs_pkg::S_STOPS: begin
				state_nxt = crcs_pkg::S_GATED;
				cnt_nxt   = settle_eff - 8'h01;
			end
			crcs_pkg::S_GATED: begin
				if (cnt_r != 8'h00) begin
					cnt_nxt = cnt_r - 8'h01;
				end else begin
					state_nxt = crcs_pkg::S_RELEASED;
					cnt_nxt   = settle_eff - 8'h01;
				end
			end
			crcs_pkg::S_RELEASED: begin
				if (cnt_r != 8'h00) begin
					cnt_nxt = cnt_r - 8'h01;
				end else begin
					state_nxt = crcs_pkg::S_IDLE;
				end
			end
			default: begin
				state_nxt = crcs_pkg::S_IDLE;
			end
		endcase
	end

	// state and counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= crcs_pkg::S_ASSERT;
			cnt_r   <= `CRCS_HOLD_RST - 8'h01;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// phase decode of the next state, so the pins change on the transition edge
	assign pat        = pattern(go ? cmd_wr : cmd_r);
	assign assert_nxt = state_nxt inside {crcs_pkg::S_ASSERT, crcs_pkg::S_STOPS, crcs_pkg::S_GATED};
	assign gate_nxt   = state_nxt inside {crcs_pkg::S_GATED, crcs_pkg::S_RELEASED};
	assign stop_nxt   = (LOCKSTEP != 0) && cluster_kind &&
		(state_nxt inside {crcs_pkg::S_STOPS, crcs_pkg::S_GATED, crcs_pkg::S_RELEASED});

	// reset pins; all asserted under rst_i, released only on a clk edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_reset_n_o           <= '0;
			debug_logic_reset_n_o    <= '0;
			watchdog_flag_reset_n_o  <= '0;
			coherency_unit_reset_n_o <= 1'b0;
			peripheral_reset_n_o     <= 1'b0;
			cross_trigger_reset_n_o  <= 1'b0;
			trace0_reset_n_o         <= 1'b0;
			trace1_reset_n_o         <= 1'b0;
		end else if (assert_nxt) begin
			core_reset_n_o           <= pat.core_n[CPUS-1:0];
			debug_logic_reset_n_o    <= pat.debug_n[CPUS-1:0];
			watchdog_flag_reset_n_o  <= pat.wd_n[CPUS-1:0];
			coherency_unit_reset_n_o <= pat.cluster_n;
			peripheral_reset_n_o     <= pat.cluster_n;
			cross_trigger_reset_n_o  <= pat.trace_n;
			trace0_reset_n_o         <= pat.trace_n;
			trace1_reset_n_o         <= pat.trace_n;
		end else begin
			core_reset_n_o           <= '1;
			debug_logic_reset_n_o    <= '1;
			watchdog_flag_reset_n_o  <= '1;
			coherency_unit_reset_n_o <= 1'b1;
			peripheral_reset_n_o     <= 1'b1;
			cross_trigger_reset_n_o  <= 1'b1;
			trace0_reset_n_o         <= 1'b1;
			trace1_reset_n_o         <= 1'b1;
		end
	end

	// one-hot stop mask of the addressed core; a call result cannot be sliced directly
	assign stop_sel = core_sel(cmd_r.cpu);

	// clock gating enables for the external gating cells
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_clock_run_o  <= 1'b1;
			core_clock_stop_o <= '0;
		end else begin
			main_clock_run_o  <= !(gate_nxt && cluster_kind);
			core_clock_stop_o <= (gate_nxt && !cluster_kind) ? stop_sel[CPUS-1:0] : '0;
		end
	end

	// lock-step clock stops; redundant stop rises with the others, falls late
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			coherency_unit_clock_stop_o       <= 1'b0;
			peripheral_clock_stop_o           <= 1'b0;
			redundant_peripheral_clock_stop_o <= 1'b0;
		end else begin
			coherency_unit_clock_stop_o       <= stop_nxt;
			peripheral_clock_stop_o           <= stop_nxt;
			redundant_peripheral_clock_stop_o <= stop_nxt | taps[RED_DELAY-1][2];
		end
	end

	// peripheral divider; a new ratio is taken only at the wrap to avoid a runt pulse
	assign pcnt_nxt = (pcnt_r >= ratio_act_r - 8'h01) ? 8'h00 : pcnt_r + 8'h01;
	assign half     = {1'b0, ratio_act_r[7:1]} + {7'h00, ratio_act_r[0]};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pcnt_r                    <= 8'h00;
			ratio_act_r               <= `CRCS_RATIO_RST;
			peripheral_clock_o        <= 1'b0;
			peripheral_clock_enable_o <= 1'b0;
		end else begin
			pcnt_r                    <= pcnt_nxt;
			ratio_act_r               <= (pcnt_nxt == 8'h00) ? at_least(ratio_r, `CRCS_RATIO_MIN) : ratio_act_r;
			peripheral_clock_o        <= (pcnt_nxt < half);
			peripheral_clock_enable_o <= (pcnt_nxt == ratio_act_r - 8'h01);
		end
	end

	// redundant copies share one delay line, depth equal to the core delay
	redundancy_delay_line #(
		.WIDTH (3),
		.DEPTH (RED_DELAY)
	) u_delay (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.in_i   ({peripheral_clock_stop_o, peripheral_clock_enable_o, peripheral_clock_o}),
		.taps_o (taps)
	);

	// delayed copies of the primary peripheral clock and enable
	assign redundant_peripheral_clock_o        = taps[RED_DELAY][0];
	assign redundant_peripheral_clock_enable_o = taps[RED_DELAY][1];

	// cycles that core 0 reset has been low, for the hold check
	logic [7:0] low_cnt_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_cnt_r <= 8'h00;
		end else if (!core_reset_n_o[0]) begin
			low_cnt_r <= (low_cnt_r == 8'hFF) ? low_cnt_r : low_cnt_r + 8'h01;
		end else begin
			low_cnt_r <= 8'h00;
		end
	end

	// stops raised while the clock still runs, gate follows one cycle later
	sequence s_stops_then_gate;
		peripheral_clock_stop_o && coherency_unit_clock_stop_o && redundant_peripheral_clock_stop_o
			&& main_clock_run_o ##1 !main_clock_run_o;
	endsequence

	property p_pen_rises;
		@(posedge clk_i) disable iff (rst_i)
		peripheral_clock_enable_o |=> $rose(peripheral_clock_o);
	endproperty
	a_pen_rises: assert property (p_pen_rises) else $error("enable not aligned to peripheral rise");

	property p_pen_single;
		@(posedge clk_i) disable iff (rst_i)
		peripheral_clock_enable_o |=> !peripheral_clock_enable_o;
	endproperty
	a_pen_single: assert property (p_pen_single) else $error("ratio below two");

	property p_hold_min;
		@(posedge clk_i) disable iff (rst_i)
		$rose(core_reset_n_o[0]) |-> (low_cnt_r >= `CRCS_HOLD_MIN);
	endproperty
	a_hold_min: assert property (p_hold_min) else $error("core reset held under ten cycles");

	property p_stops_first;
		@(posedge clk_i) disable iff (rst_i)
		(LOCKSTEP != 0) && $rose(peripheral_clock_stop_o) |-> s_stops_then_gate;
	endproperty
	a_stops_first: assert property (p_stops_first) else $error("clock stopped before clock-stops");

	property p_gated_in_reset;
		@(posedge clk_i) disable iff (rst_i)
		$fell(main_clock_run_o) |-> !coherency_unit_reset_n_o && !core_reset_n_o[0];
	endproperty
	a_gated_in_reset: assert property (p_gated_in_reset) else $error("clock stopped outside reset");

	property p_release_first;
		@(posedge clk_i) disable iff (rst_i)
		$rose(main_clock_run_o) |-> coherency_unit_reset_n_o && $past(coherency_unit_reset_n_o);
	endproperty
	a_release_first: assert property (p_release_first) else $error("clock restarted before release");

	property p_restart_stops;
		@(posedge clk_i) disable iff (rst_i)
		(LOCKSTEP != 0) && $rose(main_clock_run_o) |->
			!coherency_unit_clock_stop_o && !peripheral_clock_stop_o && redundant_peripheral_clock_stop_o;
	endproperty
	a_restart_stops: assert property (p_restart_stops) else $error("clock-stops wrong at restart");

	property p_red_stop_lag;
		@(posedge clk_i) disable iff (rst_i)
		$fell(redundant_peripheral_clock_stop_o) |->
			!$past(peripheral_clock_stop_o, RED_DELAY) && $past(peripheral_clock_stop_o, RED_DELAY + 1);
	endproperty
	a_red_stop_lag: assert property (p_red_stop_lag) else $error("redundant stop lag wrong");

	property p_red_clock;
		@(posedge clk_i) disable iff (rst_i)
		(redundant_peripheral_clock_o == $past(peripheral_clock_o, RED_DELAY)) &&
			(redundant_peripheral_clock_enable_o == $past(peripheral_clock_enable_o, RED_DELAY));
	endproperty
	a_red_clock: assert property (p_red_clock) else $error("redundant clock not a delayed copy");

	property p_sw_keeps_debug;
		@(posedge clk_i) disable iff (rst_i)
		$fell(coherency_unit_reset_n_o) && (cmd_r.kind == crcs_pkg::KIND_CLUSTER_SOFTWARE)
			|-> (&debug_logic_reset_n_o) && !(|core_reset_n_o);
	endproperty
	a_sw_keeps_debug: assert property (p_sw_keeps_debug) else $error("software reset hit debug");

	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

endmodule : cluster_reset_clock_sequencer

`default_nettype wire

// ---- design/crcs_regs.svh ----
`ifndef CRCS_REGS_SVH
`define CRCS_REGS_SVH

// register byte offsets
`define CRCS_ADR_CTRL       8'h00
`define CRCS_ADR_STATUS     8'h04
`define CRCS_ADR_RATIO      8'h08
`define CRCS_ADR_HOLD       8'h0C
`define CRCS_ADR_SETTLE     8'h10

// control fields
`define CRCS_CTRL_START     0
`define CRCS_CTRL_KIND_LO   1
`define CRCS_CTRL_TOP       5

// status fields
`define CRCS_ST_BUSY        0
`define CRCS_ST_DONE        1
`define CRCS_ST_REFUSED     2

// reset values and floors, counts in clk cycles
`define CRCS_RATIO_RST      8'h02
`define CRCS_RATIO_MIN      8'h02
`define CRCS_HOLD_RST       8'h0A
`define CRCS_HOLD_MIN       8'h0A
`define CRCS_SETTLE_RST     8'h0A
`define CRCS_SETTLE_MIN     8'h01

`endif

// ---- design/crcs_pkg.sv ----
`default_nettype none

package crcs_pkg;

	// kinds of reset sequence software can order
	typedef enum logic [2:0] {
		KIND_CLUSTER_POWERUP,
		KIND_CLUSTER_SOFTWARE,
		KIND_CORE_POWERUP,
		KIND_CORE_SOFTWARE,
		KIND_CLUSTER_DEBUG,
		KIND_CORE_DEBUG,
		KIND_WATCHDOG_FLAG
	} reset_kind_type;

	// sequencer phases
	typedef enum {
		S_IDLE,
		S_ASSERT,
		S_STOPS,
		S_GATED,
		S_RELEASED
	} seq_state_type;

	// command as written to the control register, bits 5:1
	typedef struct packed {
		logic           wd_opt;
		logic           cpu;
		reset_kind_type kind;
	} command_type;

	// reset levels for one sequence, active low, two-core wide
	typedef struct packed {
		logic [1:0] core_n;
		logic [1:0] debug_n;
		logic [1:0] wd_n;
		logic       cluster_n;
		logic       trace_n;
	} reset_pattern_type;

endpackage : crcs_pkg

`default_nettype wire

// ---- design/redundancy_delay_line.sv ----
`timescale 1ns/1ps
`default_nettype none

module redundancy_delay_line #(
	parameter int WIDTH = 3,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	// data
	input  wire logic [WIDTH-1:0]            in_i,
	output wire logic [DEPTH:0][WIDTH-1:0]   taps_o
);

	logic [WIDTH-1:0] stage_r [DEPTH:1];

	// tap 0 is the undelayed input
	assign taps_o[0] = in_i;

	// one register per cycle of delay
	for (genvar g = 1; g <= DEPTH; g++) begin : g_stage
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				stage_r[g] <= '0;
			end else begin
				stage_r[g] <= taps_o[g-1];
			end
		end
		assign taps_o[g] = stage_r[g];
	end

endmodule : redundancy_delay_line

`default_nettype wire

// ---- testbench/cluster_device_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module cluster_device_model #(
	parameter int CPUS     = 2,
	parameter int LOCKSTEP = 1
) (
	// gated main clock and peripheral timing
	input  wire logic            clk_i,
	input  wire logic            main_clock_run_i,
	input  wire logic            peripheral_clock_enable_i,
	input  wire logic            peripheral_clock_stop_i,
	// resets, active low
	input  wire logic [CPUS-1:0] core_reset_n_i,
	input  wire logic            coherency_unit_reset_n_i,
	input  wire logic            peripheral_reset_n_i,
	// observation
	output wire logic [7:0]      ticks_o,
	output wire logic [7:0]      hold_o
);
	logic [7:0] ticks_r = 8'h00;
	logic [7:0] hold_r  = 8'h00;
	logic       low_r   = 1'b0;

	assign ticks_o = ticks_r;
	assign hold_o  = hold_r;

	// timers step on enabled edges only, frozen while stopped or gated
	always @(posedge clk_i) begin
		if (main_clock_run_i && peripheral_reset_n_i && peripheral_clock_enable_i &&
			!(LOCKSTEP != 0 && peripheral_clock_stop_i)) begin
			ticks_r <= ticks_r + 8'h01;
		end
	end

	// a gated clock gives no edges, so only running cycles count toward the hold
	always @(posedge clk_i) begin
		if (main_clock_run_i) begin
			low_r <= !coherency_unit_reset_n_i && !(|core_reset_n_i);
			if (!coherency_unit_reset_n_i && !(|core_reset_n_i)) begin
				hold_r <= low_r ? hold_r + 8'h01 : 8'h01;
			end
		end
	end
endmodule : cluster_device_model

`default_nettype wire

// ---- testbench/cluster_reset_clock_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "crcs_regs.svh"

module cluster_reset_clock_sequencer_tb_top;
	logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic        wb_ack_o, main_clock_run_o, peripheral_clock_o, peripheral_clock_enable_o, redundant_peripheral_clock_o;
	logic        redundant_peripheral_clock_enable_o, peripheral_clock_stop_o, redundant_peripheral_clock_stop_o;
	logic        coherency_unit_reset_n_o, peripheral_reset_n_o, coherency_unit_clock_stop_o, cross_trigger_reset_n_o;
	logic        trace0_reset_n_o, trace1_reset_n_o;
	logic [1:0]  core_reset_n_o, debug_logic_reset_n_o, watchdog_flag_reset_n_o, core_clock_stop_o, pc_h;
	logic [7:0]  ticks, hold, t0;
	logic [2:0]  pe_h;
	int          error_cnt = 0, checks_done = 0, cycc = 0, w, k, i, n_en, n_co, n_rd;
	// expected core, debug, watchdog, coherency levels per kind, processor 1 targeted
	localparam logic [6:0] PAT [7] = '{7'h00, 7'h18, 7'h2F, 7'h3F, 7'h67, 7'h6F, 7'h7B};
	localparam logic [7:0] ADR [4] = '{8'h08, 8'h0C, 8'h10, 8'h40};
	localparam logic [7:0] RST [4] = '{8'h02, 8'h0A, 8'h0A, 8'h00};

	cluster_reset_clock_sequencer #(.CPUS(2), .LOCKSTEP(1), .RED_DELAY(2)) dut (.clk_i, .rst_i, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .main_clock_run_o,
		.peripheral_clock_o, .peripheral_clock_enable_o, .redundant_peripheral_clock_o,
		.redundant_peripheral_clock_enable_o, .core_clock_stop_o, .coherency_unit_clock_stop_o,
		.peripheral_clock_stop_o, .redundant_peripheral_clock_stop_o, .core_reset_n_o, .debug_logic_reset_n_o,
		.watchdog_flag_reset_n_o, .coherency_unit_reset_n_o, .peripheral_reset_n_o,
		.cross_trigger_reset_n_o, .trace0_reset_n_o, .trace1_reset_n_o);

	cluster_device_model #(.CPUS(2), .LOCKSTEP(1)) model (.clk_i, .main_clock_run_i(main_clock_run_o),
		.peripheral_clock_enable_i(peripheral_clock_enable_o), .peripheral_clock_stop_i(peripheral_clock_stop_o),
		.core_reset_n_i(core_reset_n_o), .coherency_unit_reset_n_i(coherency_unit_reset_n_o),
		.peripheral_reset_n_i(peripheral_reset_n_o), .ticks_o(ticks), .hold_o(hold));

	// clock and cycle count
	initial forever #50 clk_i = ~clk_i;
	always @(posedge clk_i) cycc <= cycc + 1;

	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic timeout(input string what);
		chk(what, 32'h1, 32'h0);
		report_and_stop();
	endtask : timeout

	// one classic cycle, held until ack is sampled, data taken at that edge
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
		if (n == 50) timeout("ack");
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask : bus

	task automatic poll;
		int n;
		for (n = 0; n < 100; n++) begin
			bus(1'b0, `CRCS_ADR_STATUS, 32'h0);
			if (rd[0] === 1'b0) break;
		end
		if (n == 100) timeout("busy");
	endtask : poll

	function automatic logic sig(input int s);
		case (s)
			0: return peripheral_clock_stop_o;
			1: return main_clock_run_o;
			2: return core_reset_n_o[0];
			3: return redundant_peripheral_clock_stop_o;
			4: return core_clock_stop_o[1];
			default: return watchdog_flag_reset_n_o[0];
		endcase
	endfunction : sig

	// cycles from the start edge until a pin reaches a level
	task automatic wait_for(input int s, input logic v, input int dt);
		int n;
		for (n = 0; n < 200 && sig(s) !== v; n++) begin
			@(posedge clk_i);
			#1;
		end
		if (n == 200) timeout("level");
		chk("delay", dt, cycc - w);
	endtask : wait_for

	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		poll();
		chk("cold done", 32'h2, rd);
		chk("cold hold", 32'h1, hold >= 8'h0A);
		chk("released", 7'h7F, {core_reset_n_o, debug_logic_reset_n_o, watchdog_flag_reset_n_o, coherency_unit_reset_n_o});
		for (i = 0; i < 4; i++) begin
			bus(1'b0, ADR[i], 32'h0);
			chk("reg", RST[i], rd);
		end
		// ratio three: enable, coincident rises, delayed copy, timer ticks
		bus(1'b1, `CRCS_ADR_RATIO, 32'h3);
		repeat (6) @(posedge clk_i);
		{n_en, n_co, n_rd} = '0;
		for (i = 0; i < 33; i++) begin
			@(posedge clk_i);
			#1;
			if (i == 2) t0 = ticks;
			n_co += int'(i > 2 && pe_h[0] && peripheral_clock_o && !pc_h[0]);
			n_rd += int'(i > 2 && redundant_peripheral_clock_enable_o === pe_h[1] &&
				redundant_peripheral_clock_o === pc_h[1]);
			n_en += int'(i > 2 && peripheral_clock_enable_o);
			pe_h = {pe_h[1:0], peripheral_clock_enable_o};
			pc_h = {pc_h[0], peripheral_clock_o};
		end
		chk("enables", 10, n_en);
		chk("coincident", 10, n_co);
		chk("delayed copy", 30, n_rd);
		chk("ticks", 8'h0A, ticks - t0);
		for (k = 0; k < 7; k++) begin
			bus(1'b1, `CRCS_ADR_STATUS, 32'h6);
			bus(1'b1, `CRCS_ADR_CTRL, {26'h0, 1'b0, 1'b1, 3'(k), 1'b1});
			w = cycc + 1;
			@(posedge clk_i);
			#1;
			chk("pattern", PAT[k], {core_reset_n_o, debug_logic_reset_n_o, watchdog_flag_reset_n_o, coherency_unit_reset_n_o});
			chk("aux resets", (k == 0) ? 4'h0 : (k == 1) ? 4'h7 : 4'hF,
				{peripheral_reset_n_o, cross_trigger_reset_n_o, trace0_reset_n_o, trace1_reset_n_o});
			if (k == 1) begin
				wait_for(0, 1'b1, 10);
				chk("unit stop", 32'h1, coherency_unit_clock_stop_o);
				wait_for(1, 1'b0, 11);
				wait_for(2, 1'b1, 21);
				wait_for(1, 1'b1, 31);
				chk("stops", 3'b001, {coherency_unit_clock_stop_o, peripheral_clock_stop_o, redundant_peripheral_clock_stop_o});
				wait_for(3, 1'b0, 33);
			end else if (k == 3) begin
				bus(1'b1, `CRCS_ADR_CTRL, 32'h1);
				bus(1'b0, `CRCS_ADR_STATUS, 32'h0);
				chk("refused busy", 32'h5, rd);
				wait_for(4, 1'b1, 10);
				wait_for(4, 1'b0, 30);
			end
			poll();
			chk("done", (k == 3) ? 32'h6 : 32'h2, rd);
			if (k < 2) chk("hold", 32'h1, hold >= 8'h0A);
		end
		bus(1'b0, `CRCS_ADR_CTRL, 32'h0);
		chk("command", 32'h1C, rd);
		// hold below the floor still keeps the reset ten cycles
		bus(1'b1, `CRCS_ADR_HOLD, 32'h3);
		bus(1'b0, `CRCS_ADR_HOLD, 32'h0);
		chk("hold reg", 32'h3, rd);
		bus(1'b1, `CRCS_ADR_CTRL, 32'h2D);
		w = cycc + 1;
		wait_for(5, 1'b0, 1);
		wait_for(5, 1'b1, 10);
		poll();
		bus(1'b1, `CRCS_ADR_STATUS, 32'h6);
		bus(1'b1, `CRCS_ADR_CTRL, 32'hF);
		bus(1'b0, `CRCS_ADR_STATUS, 32'h0);
		chk("bad kind", 32'h4, rd);
		report_and_stop();
	end
endmodule : cluster_reset_clock_sequencer_tb_top

`default_nettype wire
